//--- verilog/radio_irq_map.sv
// Interrupt pin routing, FIFO control and event status registers of the radio
//
// Functional notes
// - Receive continuous: pin A pattern, level, start
// - Receive buffered: pin A low, byte, nonempty, start
// - Receive packet: pin A ready, byte, nonempty, match/start
// - Receive continuous: pin B carries recovered clock
// - Receive buffered: pin B low, full, level, threshold
// - Receive packet: pin B crc, full, level, threshold
// - Transmit pin B: clock, full or done
// - Read-only full bit 1, nonempty bit 0
// - Fill on pattern, or while fill-start set
// - Fill-start set by pattern; write controls it
// - Transmit-done bit shows last bit handed over
// - Buffered: writing overflow one flushes FIFO
// - Packet: overflow write flushes, new packet ready
// - Level enable gates signal-present flag setting
// - Signal-present latches, cleared by writing one
// - Lock flag latches on lock, write-one clears
// - Lock pin high unless enabled, then live
// - Reset values 0x00 and 0x01
// - Level compared with eight-bit threshold
// - FIFO threshold at count of field plus one
`timescale 1ns/10ps
module radio_irq_map #(
   parameter int COUNT_W = 7,
   parameter int THRESH_W = 6
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input irq_map_pkg::core_status_t core_status,
   input wire logic synth_lock_pin,
   input irq_map_pkg::cfg_req_t cfg_req,
   output logic [7:0] cfg_rdata,
   output logic host_int_pin_a,
   output logic host_int_pin_b,
   output logic lock_indicator_pin,
   output logic fifo_fill_enable,
   output logic fifo_flush,
   output logic pattern_rearm
);
   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   if (COUNT_W != 7 || THRESH_W != 6) begin : g_width_check
      $error("radio_irq_map: count widths must match the status carrier");
   end

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [1:0] rx_pin_a_select;
   logic [1:0] rx_pin_b_select;
   logic tx_pin_a_select;
   logic tx_pin_b_select;
   logic fill_mode;
   logic fill_start;
   logic level_event_enable;
   logic signal_present_flag;
   logic synth_locked_flag;
   logic lock_out_enable;
   logic lock_seen;
   logic [1:0] next_rx_pin_a_select;
   logic [1:0] next_rx_pin_b_select;
   logic next_tx_pin_a_select;
   logic next_tx_pin_b_select;
   logic next_fill_mode;
   logic next_fill_start;
   logic next_level_event_enable;
   logic next_signal_present_flag;
   logic next_synth_locked_flag;
   logic next_lock_out_enable;
   logic [7:0] next_cfg_rdata;
   logic next_fifo_flush;
   logic next_pattern_rearm;
   logic next_pin_a;
   logic next_pin_b;
   logic next_lock_pin;
   logic synth_lock;
   logic level_event;
   logic fifo_threshold_event;
   logic write_select;
   logic write_status;
   logic [7:0] select_view;
   logic [7:0] status_view;

   pin_sync #(
      .WIDTH(1)
   ) lock_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .pin_in(synth_lock_pin),
      .pin_out(synth_lock)
   );

   // ----------------------------------------
   // Events
   // ----------------------------------------
   always_comb begin
      level_event = core_status.rssi_level >= core_status.level_threshold;
      fifo_threshold_event = core_status.fifo_count >=
         ({1'b0, core_status.fifo_threshold} + 7'h01);
   end

   // ----------------------------------------
   // Register address decode
   // ----------------------------------------
   always_comb begin
      write_select = cfg_req.write && cfg_req.addr == irq_map_pkg::SOURCE_SELECT_ADDR;
      write_status = cfg_req.write && cfg_req.addr == irq_map_pkg::EVENT_STATUS_ADDR;
   end

   // ----------------------------------------
   // Register views
   // ----------------------------------------
   always_comb begin
      select_view = 8'h00;
      select_view[irq_map_pkg::RX_A_SEL_HI:irq_map_pkg::RX_A_SEL_LO] = rx_pin_a_select;
      select_view[irq_map_pkg::RX_B_SEL_HI:irq_map_pkg::RX_B_SEL_LO] = rx_pin_b_select;
      select_view[irq_map_pkg::TX_A_SEL_BIT] = tx_pin_a_select;
      select_view[irq_map_pkg::TX_B_SEL_BIT] = tx_pin_b_select;
      select_view[irq_map_pkg::FULL_BIT] = core_status.fifo_full;
      select_view[irq_map_pkg::NOT_EMPTY_BIT] = core_status.fifo_not_empty;
      status_view = 8'h00;
      status_view[irq_map_pkg::FILL_MODE_BIT] = fill_mode;
      status_view[irq_map_pkg::FILL_START_BIT] = fill_start;
      status_view[irq_map_pkg::TX_DONE_BIT] = core_status.tx_last_bit;
      status_view[irq_map_pkg::OVERFLOW_BIT] = core_status.fifo_overflow;
      status_view[irq_map_pkg::LEVEL_ENABLE_BIT] = level_event_enable;
      status_view[irq_map_pkg::SIGNAL_PRESENT_BIT] = signal_present_flag;
      status_view[irq_map_pkg::LOCKED_BIT] = synth_locked_flag;
      status_view[irq_map_pkg::LOCK_PIN_ENABLE_BIT] = lock_out_enable;
   end

   // ----------------------------------------
   // Source select writes
   // ----------------------------------------
   always_comb begin
      next_rx_pin_a_select = rx_pin_a_select;
      next_rx_pin_b_select = rx_pin_b_select;
      next_tx_pin_a_select = tx_pin_a_select;
      next_tx_pin_b_select = tx_pin_b_select;
      if (write_select) begin
         next_rx_pin_a_select =
            cfg_req.wdata[irq_map_pkg::RX_A_SEL_HI:irq_map_pkg::RX_A_SEL_LO];
         next_rx_pin_b_select =
            cfg_req.wdata[irq_map_pkg::RX_B_SEL_HI:irq_map_pkg::RX_B_SEL_LO];
         next_tx_pin_a_select = cfg_req.wdata[irq_map_pkg::TX_A_SEL_BIT];
         next_tx_pin_b_select = cfg_req.wdata[irq_map_pkg::TX_B_SEL_BIT];
      end
   end

   // ----------------------------------------
   // Control writes and flags
   // ----------------------------------------
   always_comb begin
      next_fill_mode = fill_mode;
      next_fill_start = fill_start;
      next_level_event_enable = level_event_enable;
      next_signal_present_flag = signal_present_flag;
      next_synth_locked_flag = synth_locked_flag;
      next_lock_out_enable = lock_out_enable;
      next_fifo_flush = 1'b0;
      next_pattern_rearm = 1'b0;
      if (write_status) begin
         next_fill_mode = cfg_req.wdata[irq_map_pkg::FILL_MODE_BIT];
         next_level_event_enable = cfg_req.wdata[irq_map_pkg::LEVEL_ENABLE_BIT];
         next_lock_out_enable = cfg_req.wdata[irq_map_pkg::LOCK_PIN_ENABLE_BIT];
         if (fill_mode) begin
            next_fill_start = cfg_req.wdata[irq_map_pkg::FILL_START_BIT];
         end else if (cfg_req.wdata[irq_map_pkg::FILL_START_BIT]) begin
            next_fill_start = 1'b0;
            next_pattern_rearm = 1'b1;
         end
         if (cfg_req.wdata[irq_map_pkg::OVERFLOW_BIT] &&
             core_status.data_mode != irq_map_pkg::MODE_CONTINUOUS) begin
            next_fifo_flush = 1'b1;
         end
         if (cfg_req.wdata[irq_map_pkg::SIGNAL_PRESENT_BIT]) begin
            next_signal_present_flag = 1'b0;
         end
         if (cfg_req.wdata[irq_map_pkg::LOCKED_BIT]) begin
            next_synth_locked_flag = 1'b0;
         end
      end
      // Hardware set wins over a clear in the same cycle
      if (!fill_mode && core_status.start_detect) begin
         next_fill_start = 1'b1;
      end
      if (level_event_enable && level_event) begin
         next_signal_present_flag = 1'b1;
      end
      if (synth_lock && !lock_seen) begin
         next_synth_locked_flag = 1'b1;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_comb begin
      next_cfg_rdata = 8'h00;
      if (cfg_req.read) begin
         unique case (cfg_req.addr)
            irq_map_pkg::SOURCE_SELECT_ADDR: next_cfg_rdata = select_view;
            irq_map_pkg::EVENT_STATUS_ADDR: next_cfg_rdata = status_view;
            default: next_cfg_rdata = 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // Pin source routing
   // ----------------------------------------
   always_comb begin
      next_pin_a = 1'b0;
      next_pin_b = 1'b0;
      if (core_status.direction_tx) begin
         if (core_status.data_mode == irq_map_pkg::MODE_CONTINUOUS) begin
            next_pin_a = 1'b0;
            next_pin_b = core_status.recovered_bit_clock;
         end else begin
            next_pin_a = tx_pin_a_select ? core_status.fifo_not_empty
                                         : fifo_threshold_event;
            next_pin_b = tx_pin_b_select ? core_status.tx_last_bit
                                         : core_status.fifo_full;
         end
      end else begin
         unique case (core_status.data_mode)
            irq_map_pkg::MODE_CONTINUOUS: begin
               unique case (rx_pin_a_select)
                  2'h0: next_pin_a = core_status.pattern_bit;
                  2'h1: next_pin_a = level_event;
                  default: next_pin_a = core_status.start_detect;
               endcase
               next_pin_b = core_status.recovered_bit_clock;
            end
            irq_map_pkg::MODE_BUFFERED: begin
               unique case (rx_pin_a_select)
                  2'h0: next_pin_a = 1'b0;
                  2'h1: next_pin_a = core_status.write_byte;
                  2'h2: next_pin_a = core_status.fifo_not_empty;
                  default: next_pin_a = core_status.start_detect;
               endcase
               unique case (rx_pin_b_select)
                  2'h0: next_pin_b = 1'b0;
                  2'h1: next_pin_b = core_status.fifo_full;
                  2'h2: next_pin_b = level_event;
                  default: next_pin_b = fifo_threshold_event;
               endcase
            end
            default: begin
               unique case (rx_pin_a_select)
                  2'h0: next_pin_a = core_status.data_ready;
                  2'h1: next_pin_a = core_status.write_byte;
                  2'h2: next_pin_a = core_status.fifo_not_empty;
                  default: next_pin_a = core_status.node_match_enable
                     ? core_status.node_match : core_status.start_detect;
               endcase
               unique case (rx_pin_b_select)
                  2'h0: next_pin_b = core_status.crc_ok;
                  2'h1: next_pin_b = core_status.fifo_full;
                  2'h2: next_pin_b = level_event;
                  default: next_pin_b = fifo_threshold_event;
               endcase
            end
         endcase
      end
   end

   // ----------------------------------------
   // Lock indicator
   // ----------------------------------------
   always_comb begin
      next_lock_pin = lock_out_enable ? synth_lock : 1'b1;
   end

   // ----------------------------------------
   // Source select registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rx_pin_a_select <= irq_map_pkg::SOURCE_SELECT_RESET[7:6];
         rx_pin_b_select <= irq_map_pkg::SOURCE_SELECT_RESET[5:4];
         tx_pin_a_select <= irq_map_pkg::SOURCE_SELECT_RESET[3];
         tx_pin_b_select <= irq_map_pkg::SOURCE_SELECT_RESET[2];
      end else begin
         rx_pin_a_select <= next_rx_pin_a_select;
         rx_pin_b_select <= next_rx_pin_b_select;
         tx_pin_a_select <= next_tx_pin_a_select;
         tx_pin_b_select <= next_tx_pin_b_select;
      end
   end

   // ----------------------------------------
   // Control and status registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         fill_mode <= irq_map_pkg::EVENT_STATUS_RESET[7];
         fill_start <= irq_map_pkg::EVENT_STATUS_RESET[6];
         level_event_enable <= irq_map_pkg::EVENT_STATUS_RESET[3];
         signal_present_flag <= irq_map_pkg::EVENT_STATUS_RESET[2];
         synth_locked_flag <= irq_map_pkg::EVENT_STATUS_RESET[1];
         lock_out_enable <= irq_map_pkg::EVENT_STATUS_RESET[0];
         lock_seen <= 1'b0;
      end else begin
         fill_mode <= next_fill_mode;
         fill_start <= next_fill_start;
         level_event_enable <= next_level_event_enable;
         signal_present_flag <= next_signal_present_flag;
         synth_locked_flag <= next_synth_locked_flag;
         lock_out_enable <= next_lock_out_enable;
         lock_seen <= synth_lock;
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cfg_rdata <= 8'h00;
         fifo_flush <= 1'b0;
         pattern_rearm <= 1'b0;
         host_int_pin_a <= 1'b0;
         host_int_pin_b <= 1'b0;
         lock_indicator_pin <= 1'b1;
         fifo_fill_enable <= 1'b0;
      end else begin
         cfg_rdata <= next_cfg_rdata;
         fifo_flush <= next_fifo_flush;
         pattern_rearm <= next_pattern_rearm;
         host_int_pin_a <= next_pin_a;
         host_int_pin_b <= next_pin_b;
         lock_indicator_pin <= next_lock_pin;
         fifo_fill_enable <= next_fill_start;
      end
   end
endmodule : radio_irq_map

//--- include/irq_map_pkg.sv
// Constants and carrier types for the interrupt mapping and status block
package irq_map_pkg;
   // Register offsets
   localparam logic [7:0] SOURCE_SELECT_ADDR = 8'h0D;
   localparam logic [7:0] EVENT_STATUS_ADDR = 8'h0E;
   // Reset values
   localparam logic [7:0] SOURCE_SELECT_RESET = 8'h00;
   localparam logic [7:0] EVENT_STATUS_RESET = 8'h01;
   // Source select field positions
   localparam int RX_A_SEL_HI = 7;
   localparam int RX_A_SEL_LO = 6;
   localparam int RX_B_SEL_HI = 5;
   localparam int RX_B_SEL_LO = 4;
   localparam int TX_A_SEL_BIT = 3;
   localparam int TX_B_SEL_BIT = 2;
   localparam int FULL_BIT = 1;
   localparam int NOT_EMPTY_BIT = 0;
   // Control and status field positions
   localparam int FILL_MODE_BIT = 7;
   localparam int FILL_START_BIT = 6;
   localparam int TX_DONE_BIT = 5;
   localparam int OVERFLOW_BIT = 4;
   localparam int LEVEL_ENABLE_BIT = 3;
   localparam int SIGNAL_PRESENT_BIT = 2;
   localparam int LOCKED_BIT = 1;
   localparam int LOCK_PIN_ENABLE_BIT = 0;
   // Synchroniser depth for pin inputs
   localparam int SYNC_STAGES = 3;

   typedef enum logic [1:0] {
      MODE_CONTINUOUS = 2'h0,
      MODE_BUFFERED = 2'h1,
      MODE_PACKET = 2'h2
   } data_mode_t;

   // Live status of the radio core, same clock as this block
   typedef struct packed {
      logic direction_tx;
      data_mode_t data_mode;
      logic pattern_bit;
      logic start_detect;
      logic write_byte;
      logic data_ready;
      logic node_match;
      logic node_match_enable;
      logic crc_ok;
      logic recovered_bit_clock;
      logic fifo_full;
      logic fifo_not_empty;
      logic fifo_overflow;
      logic tx_last_bit;
      logic [6:0] fifo_count;
      logic [5:0] fifo_threshold;
      logic [7:0] rssi_level;
      logic [7:0] level_threshold;
   } core_status_t;

   // Host register port request
   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cfg_req_t;
endpackage : irq_map_pkg

//--- verilog/pin_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_out;

   if (irq_map_pkg::SYNC_STAGES != 3 || WIDTH < 1) begin : g_config_check
      $error("pin_sync: unsupported configuration");
   end

   // ----------------------------------------
   // Accept value on agreement
   // ----------------------------------------
   always_comb begin
      next_out = pin_out;
      for (int i = 0; i < WIDTH; i++) begin
         if (stage2[i] == stage3[i]) begin
            next_out[i] = stage3[i];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         pin_out <= '0;
      end else begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
         pin_out <= next_out;
      end
   end
endmodule : pin_sync

//--- testbench/host_pin_monitor.sv
// Host side model: counts transmit starts seen on interrupt pin A
`timescale 1ns/10ps
module host_pin_monitor (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic host_int_pin_a,
   output logic [15:0] tx_starts
);
   logic pin_q;
   always_ff @(posedge sys_clk) begin
      pin_q <= host_int_pin_a;
      if (sys_rst) begin
         tx_starts <= 16'h0000;
      end else if (host_int_pin_a && !pin_q) begin
         tx_starts <= tx_starts + 16'h0001;
      end
   end
endmodule : host_pin_monitor

//--- testbench/radio_irq_map_assertions.sv
// Port checker for the interrupt mapping block
`timescale 1ns/10ps
module radio_irq_map_checker (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input irq_map_pkg::core_status_t core_status,
   input wire logic synth_lock_pin,
   input irq_map_pkg::cfg_req_t cfg_req,
   input wire logic [7:0] cfg_rdata,
   input wire logic host_int_pin_a,
   input wire logic host_int_pin_b,
   input wire logic lock_indicator_pin,
   input wire logic fifo_fill_enable,
   input wire logic fifo_flush,
   input wire logic pattern_rearm
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   wire cont = core_status.data_mode == irq_map_pkg::MODE_CONTINUOUS;
   wire tx = core_status.direction_tx;
   wire w1_ovf = cfg_req.write && cfg_req.addr == 8'h0E && cfg_req.wdata[4];
   wire w1_fill = cfg_req.write && cfg_req.addr == 8'h0E && cfg_req.wdata[6];
   sequence s_read(logic [7:0] a);
      cfg_req.read && cfg_req.addr == a;
   endsequence
   property p_reset_quiet;
      disable iff (1'b0) sys_rst |=> !host_int_pin_a && !host_int_pin_b && lock_indicator_pin
         && cfg_rdata == 8'h00;
   endproperty
   property p_rx_cont_b;
      !tx && cont |=> host_int_pin_b == $past(core_status.recovered_bit_clock);
   endproperty
   property p_tx_cont_a;
      tx && cont |=> !host_int_pin_a;
   endproperty
   property p_tx_cont_b;
      tx && cont |=> host_int_pin_b == $past(core_status.recovered_bit_clock);
   endproperty
   property p_full_bits;
      s_read(8'h0D) |=> cfg_rdata[1] == $past(core_status.fifo_full)
         && cfg_rdata[0] == $past(core_status.fifo_not_empty);
   endproperty
   property p_tx_done;
      s_read(8'h0E) |=> cfg_rdata[5] == $past(core_status.tx_last_bit);
   endproperty
   property p_flush_on_write;
      w1_ovf && !cont |=> fifo_flush;
   endproperty
   property p_no_stray_flush;
      !(w1_ovf && !cont) |=> !fifo_flush;
   endproperty
   property p_rearm_cause;
      pattern_rearm |-> $past(w1_fill);
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet in reset");
   a_rx_cont_b: assert property (p_rx_cont_b) else $error("pin B not bit clock in rx");
   a_tx_cont_a: assert property (p_tx_cont_a) else $error("pin A not low in tx");
   a_tx_cont_b: assert property (p_tx_cont_b) else $error("pin B not bit clock in tx");
   a_full_bits: assert property (p_full_bits) else $error("fifo status bits wrong");
   a_tx_done: assert property (p_tx_done) else $error("tx done bit wrong");
   a_flush_on_write: assert property (p_flush_on_write) else $error("flush missing");
   a_no_stray_flush: assert property (p_no_stray_flush) else $error("stray flush");
   a_rearm_cause: assert property (p_rearm_cause) else $error("stray rearm pulse");
endmodule : radio_irq_map_checker

bind radio_irq_map radio_irq_map_checker radio_irq_map_checker_i (.sys_clk, .sys_rst,
   .core_status, .synth_lock_pin, .cfg_req, .cfg_rdata, .host_int_pin_a, .host_int_pin_b,
   .lock_indicator_pin, .fifo_fill_enable, .fifo_flush, .pattern_rearm);

//--- testbench/tb_radio_irq_map.sv
// Self-checking bench for the interrupt mapping block
`timescale 1ns/10ps
module tb_radio_irq_map;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   irq_map_pkg::core_status_t core_status = '0;
   irq_map_pkg::core_status_t c;
   logic synth_lock_pin = 1'b0;
   irq_map_pkg::cfg_req_t cfg_req = '0;
   logic [7:0] cfg_rdata;
   logic host_int_pin_a, host_int_pin_b, lock_indicator_pin;
   logic fifo_fill_enable, fifo_flush, pattern_rearm;
   logic [15:0] tx_starts;
   logic [7:0] sel;
   logic [11:0] v;
   int failures = 0;
   int comparisons = 0;

   radio_irq_map radio_irq_map_i (.sys_clk, .sys_rst, .core_status, .synth_lock_pin, .cfg_req,
      .cfg_rdata, .host_int_pin_a, .host_int_pin_b, .lock_indicator_pin, .fifo_fill_enable,
      .fifo_flush, .pattern_rearm);
   host_pin_monitor host_pin_monitor_i (.sys_clk, .sys_rst, .host_int_pin_a, .tx_starts);

   initial begin
      forever #25 sys_clk = ~sys_clk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk) cfg_req <= '{1'b1, 1'b0, a, d};
      @(posedge sys_clk) cfg_req <= '0;
      #1;
   endtask : reg_write
   task read_check(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk) cfg_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge sys_clk) cfg_req <= '0;
      #1 check(cfg_rdata, exp);
   endtask : read_check
   task cs_step;
      @(posedge sys_clk) core_status <= c;
      @(posedge sys_clk);
      #1;
   endtask : cs_step
   task give_verdict;
      $display("Comparisons %0d, failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   function automatic logic route(input irq_map_pkg::core_status_t s_c, input logic [7:0] s,
                                  input bit b);
      logic lv;
      logic th;
      logic [3:0] pick;
      lv = s_c.rssi_level >= s_c.level_threshold;
      th = s_c.fifo_count >= ({1'b0, s_c.fifo_threshold} + 7'h01);
      if (s_c.direction_tx) begin
         if (s_c.data_mode == irq_map_pkg::MODE_CONTINUOUS) return b & s_c.recovered_bit_clock;
         return b ? (s[2] ? s_c.tx_last_bit : s_c.fifo_full) : (s[3] ? s_c.fifo_not_empty : th);
      end
      if (s_c.data_mode == irq_map_pkg::MODE_CONTINUOUS)
         pick = b ? {4{s_c.recovered_bit_clock}} : {s_c.start_detect, s_c.start_detect, lv,
                                                    s_c.pattern_bit};
      else if (s_c.data_mode == irq_map_pkg::MODE_BUFFERED)
         pick = b ? {th, lv, s_c.fifo_full, 1'b0} : {s_c.start_detect, s_c.fifo_not_empty,
                                                    s_c.write_byte, 1'b0};
      else
         pick = b ? {th, lv, s_c.fifo_full, s_c.crc_ok} : {s_c.node_match_enable ?
            s_c.node_match : s_c.start_detect, s_c.fifo_not_empty, s_c.write_byte, s_c.data_ready};
      return b ? pick[s[5:4]] : pick[s[7:6]];
   endfunction : route

   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      give_verdict();
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      read_check(8'h0D, 8'h00);
      read_check(8'h0E, 8'h01);
      reg_write(8'h20, 8'hFF);
      read_check(8'h20, 8'h00);
      $display("Test reset values done");
      for (int sv = 0; sv < 4; sv++) begin
         sel = {4{sv[1:0]}} & 8'hFC;
         reg_write(8'h0D, sel);
         for (int m = 0; m < 8; m++) begin
            for (int k = 0; k < 26; k++) begin
               v = (k % 13 < 12) ? (12'h001 << (k % 13)) : 12'h000;
               c = '0;
               c.direction_tx = m[2];
               c.data_mode = irq_map_pkg::data_mode_t'(m[1:0]);
               c.node_match_enable = k >= 13;
               {c.pattern_bit, c.start_detect, c.write_byte, c.data_ready, c.node_match,
                c.crc_ok, c.recovered_bit_clock, c.fifo_full, c.fifo_not_empty,
                c.tx_last_bit} = v[9:0];
               c.rssi_level = v[10] ? 8'h80 : 8'h7F;
               c.level_threshold = 8'h80;
               c.fifo_threshold = 6'h05;
               c.fifo_count = v[11] ? 7'h06 : 7'h05;
               cs_step();
               check(host_int_pin_a, route(c, sel, 1'b0));
               check(host_int_pin_b, route(c, sel, 1'b1));
            end
         end
      end
      $display("Test pin routing done");
      c = '0;
      c.rssi_level = 8'h90;
      c.level_threshold = 8'h90;
      cs_step();
      reg_write(8'h0E, 8'h41);
      read_check(8'h0E, 8'h01);
      reg_write(8'h0E, 8'h09);
      read_check(8'h0E, 8'h0D);
      c.rssi_level = 8'h8F;
      cs_step();
      read_check(8'h0E, 8'h0D);
      reg_write(8'h0E, 8'h0D);
      read_check(8'h0E, 8'h09);
      $display("Test signal flag done");
      @(posedge sys_clk) synth_lock_pin <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1 check(lock_indicator_pin, 8'h01);
      read_check(8'h0E, 8'h0B);
      @(posedge sys_clk) synth_lock_pin <= 1'b0;
      repeat (6) @(posedge sys_clk);
      #1 check(lock_indicator_pin, 8'h00);
      read_check(8'h0E, 8'h0B);
      reg_write(8'h0E, 8'h02);
      @(posedge sys_clk);
      #1 check(lock_indicator_pin, 8'h01);
      read_check(8'h0E, 8'h00);
      $display("Test lock flag done");
      c = '0;
      c.start_detect = 1'b1;
      cs_step();
      check(fifo_fill_enable, 8'h01);
      c = '0;
      cs_step();
      read_check(8'h0E, 8'h40);
      reg_write(8'h0E, 8'h40);
      check(pattern_rearm, 8'h01);
      check(fifo_fill_enable, 8'h00);
      reg_write(8'h0E, 8'h80);
      reg_write(8'h0E, 8'hC0);
      check(fifo_fill_enable, 8'h01);
      reg_write(8'h0E, 8'h80);
      check(fifo_fill_enable, 8'h00);
      $display("Test fifo fill done");
      c.data_mode = irq_map_pkg::MODE_BUFFERED;
      c.fifo_full = 1'b1;
      c.tx_last_bit = 1'b1;
      c.fifo_overflow = 1'b1;
      cs_step();
      reg_write(8'h0D, 8'hFF);
      read_check(8'h0D, 8'hFE);
      read_check(8'h0E, 8'hB0);
      reg_write(8'h0E, 8'h90);
      check(fifo_flush, 8'h01);
      c.data_mode = irq_map_pkg::MODE_PACKET;
      cs_step();
      reg_write(8'h0E, 8'h90);
      check(fifo_flush, 8'h01);
      c.data_mode = irq_map_pkg::MODE_CONTINUOUS;
      cs_step();
      reg_write(8'h0E, 8'h90);
      check(fifo_flush, 8'h00);
      sel = tx_starts[7:0];
      c.direction_tx = 1'b1;
      c.data_mode = irq_map_pkg::MODE_BUFFERED;
      c.fifo_not_empty = 1'b1;
      cs_step();
      c.fifo_not_empty = 1'b0;
      cs_step();
      check(tx_starts[7:0], sel + 8'h01);
      $display("Test status and flush done");
      give_verdict();
   end
endmodule : tb_radio_irq_map
